// *** hdl/scan_port_pkg.sv ***
// Constants, codes and types shared by the boundary-scan test port.
package scan_port_pkg;
   // Register lengths.
   localparam int IR_LEN   = 10;              // Instruction register length.
   localparam int ID_LEN   = 32;              // Identification register length.
   localparam int PIN_NUM  = 8;               // Number of user pins in the boundary.
   localparam int BSR_LEN  = 2 * PIN_NUM;     // Value cells low, enable cells high.
   localparam int STD_W    = 2;               // Width of one pin's I/O standard code.
   localparam int STD_LEN  = PIN_NUM * STD_W; // I/O standard chain length.
   localparam int CFG_W    = 8;               // Width of one configuration byte.
   localparam int CNT_W    = 3;               // Bit counter width for one byte.

   // Instruction codes.
   localparam logic [IR_LEN-1:0] INS_EXTEST    = 10'h000;
   localparam logic [IR_LEN-1:0] INS_CFG_LOAD  = 10'h002;
   localparam logic [IR_LEN-1:0] INS_SAMPLE    = 10'h005;
   localparam logic [IR_LEN-1:0] INS_ID_READ   = 10'h006;
   localparam logic [IR_LEN-1:0] INS_HIGHZ     = 10'h00b;
   localparam logic [IR_LEN-1:0] INS_CONFIG_IO = 10'h00d;
   localparam logic [IR_LEN-1:0] INS_BYPASS    = 10'h3ff;
   localparam logic [IR_LEN-1:0] IR_CAPTURE    = 10'h001; // Fixed 01 in the low bits.

   // Identification value; the value is arbitrary, its lowest bit is one.
   localparam logic [ID_LEN-1:0] ID_VALUE      = 32'h0a5c_3e01;
   localparam logic [STD_LEN-1:0] STD_RESET    = 16'h0000; // Default I/O standard codes.
   localparam logic [CNT_W-1:0]   CNT_LAST     = 3'h7;     // Last bit of a byte.

   // Test state machine states.
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } tap_state_t;

   // Data register that sits between serial input and output.
   typedef enum logic [2:0] {
      PATH_BYPASS, PATH_ID, PATH_BSR, PATH_STD, PATH_CFG
   } dr_path_t;

   // Maps an instruction to its data path; unknown codes take the bypass path.
   function automatic dr_path_t path_of(input logic [IR_LEN-1:0] ins);
      dr_path_t p;
      p = PATH_BYPASS;
      if (ins == INS_ID_READ) begin
         p = PATH_ID;
      end else if (ins == INS_EXTEST || ins == INS_SAMPLE) begin
         p = PATH_BSR;
      end else if (ins == INS_CONFIG_IO) begin
         p = PATH_STD;
      end else if (ins == INS_CFG_LOAD) begin
         p = PATH_CFG;
      end
      return p;
   endfunction
endpackage

// *** hdl/level_sync.sv ***
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/10ps
module level_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock.
   input  wire logic             clk_in,
   // Level from another domain.
   input  wire logic [WIDTH-1:0] d_in,
   // Synchronised level.
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_reg; // First stage, read only by the second.

   // Both stages run freely; no reset is needed for a pure delay line.
   always_ff @(posedge clk_in) begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
   end
endmodule // level_sync

// *** hdl/boundary_scan_test_port.sv ***
// Boundary-scan test port: test state machine, scan registers and pin control.
// Contract
// - Standard test state machine and mandatory instructions.
// - Configuration data loads through the scan port.
// - Scan chain rewrites every pin's I/O standard.
// - Sample/preload snapshots pins without disturbing them.
// - Extest drives pattern, captures input pins.
// - All-ones code selects one-bit bypass.
// - Pins stay undriven until configuration completes, except under extest, which drives its pattern at once.
// - Instruction register is exactly ten bits.
// - Identification register shifts out, lowest bit one.
// - High-z code: bypass path, pins released.
// - Config-I/O halts configuration, holds status low.
`timescale 1ns/10ps
module boundary_scan_test_port
   import scan_port_pkg::*;
(
   // System clock and reset.
   input  wire logic               clk_sys_in,
   input  wire logic               rst_b_in,
   // Test port pins.
   input  wire logic               tck_in,
   input  wire logic               tms_in,
   input  wire logic               tdi_in,
   output logic                    tdo_out,
   output logic                    tdo_oe_out,
   // Core side of the pins.
   input  wire logic [PIN_NUM-1:0] core_out_in,
   input  wire logic [PIN_NUM-1:0] core_oe_in,
   input  wire logic [PIN_NUM-1:0] pin_in_in,
   input  wire logic               config_done_in,
   input  wire logic               reconfig_start_in,
   // Pin drive and configuration outputs.
   output logic      [PIN_NUM-1:0] pin_out_out,
   output logic      [PIN_NUM-1:0] pin_oe_out,
   output logic      [STD_LEN-1:0] io_std_out,
   output logic                    config_status_low_active_out,
   output logic      [CFG_W-1:0]   cfg_byte_out,
   output logic                    cfg_valid_out
);
   // ---------------- Test clock domain ----------------
   logic               tck_rst_b;       // System reset seen in the test clock domain.
   logic [PIN_NUM-1:0] pin_in_s;        // Pin levels for capture.
   logic [PIN_NUM-1:0] core_oe_s;       // Core enables for capture.
   logic               upd_ack_s;       // Update acknowledge from system side.
   logic               cfg_ack_s;       // Byte acknowledge from system side.
   tap_state_t         tap_reg;         // Test state machine.
   tap_state_t         tap_next;        // Next test state.
   logic [IR_LEN-1:0]  ir_shift_reg;    // Instruction shift stage.
   logic [IR_LEN-1:0]  ir_reg;          // Active instruction.
   logic [IR_LEN-1:0]  ir_next;         // Instruction in force after this edge.
   dr_path_t           path;            // Selected data path.
   logic               bypass_reg;      // One-bit bypass stage.
   logic [ID_LEN-1:0]  id_shift_reg;    // Identification shift stage.
   logic [BSR_LEN-1:0] bsr_shift_reg;   // Boundary shift stage.
   logic [BSR_LEN-1:0] bsr_upd_reg;     // Boundary update stage.
   logic [STD_LEN-1:0] std_shift_reg;   // I/O standard shift stage.
   logic [STD_LEN-1:0] std_upd_reg;     // I/O standard update stage.
   logic [BSR_LEN-1:0] bsr_upd_next;    // Boundary update value after this edge.
   logic [STD_LEN-1:0] std_upd_next;    // I/O standard update value after this edge.
   logic [CFG_W-1:0]   cfg_shift_reg;   // Configuration byte assembly.
   logic [CNT_W-1:0]   cfg_cnt_reg;     // Bits gathered in the current byte.
   logic [CFG_W-1:0]   cfg_hold_reg;    // Byte offered to the system side.
   logic               cfg_req_reg;     // Byte request toggle.
   logic [BSR_LEN-1:0] bsr_hold_reg;    // Boundary pattern offered to system side.
   logic [STD_LEN-1:0] std_hold_reg;    // I/O standards offered to system side.
   logic               upd_req_reg;     // Update request toggle.
   logic [2:0]         mode_reg;        // Extest, high-z and config-I/O levels.
   logic               sel_out;         // Serial output of the selected path.
   logic               upd_ack_reg;     // Update acknowledge toggle, system domain.
   logic               cfg_ack_reg;     // Byte acknowledge toggle, system domain.

   level_sync #(.WIDTH(1)) u_rst_sync (.clk_in(tck_in), .d_in(rst_b_in), .q_out(tck_rst_b));
   level_sync #(.WIDTH(2*PIN_NUM+2)) u_tck_sync (
      .clk_in (tck_in),
      .d_in   ({pin_in_in, core_oe_in, upd_ack_reg, cfg_ack_reg}),
      .q_out  ({pin_in_s, core_oe_s, upd_ack_s, cfg_ack_s})
   );

   // Next state of the test state machine from the mode select pin.
   always_comb begin
      unique case (tap_reg)
         TLR:    tap_next = tms_in ? TLR    : RTI;
         RTI:    tap_next = tms_in ? SEL_DR : RTI;
         SEL_DR: tap_next = tms_in ? SEL_IR : CAP_DR;
         CAP_DR: tap_next = tms_in ? EX1_DR : SHF_DR;
         SHF_DR: tap_next = tms_in ? EX1_DR : SHF_DR;
         EX1_DR: tap_next = tms_in ? UPD_DR : PAU_DR;
         PAU_DR: tap_next = tms_in ? EX2_DR : PAU_DR;
         EX2_DR: tap_next = tms_in ? UPD_DR : SHF_DR;
         UPD_DR: tap_next = tms_in ? SEL_DR : RTI;
         SEL_IR: tap_next = tms_in ? TLR    : CAP_IR;
         CAP_IR: tap_next = tms_in ? EX1_IR : SHF_IR;
         SHF_IR: tap_next = tms_in ? EX1_IR : SHF_IR;
         EX1_IR: tap_next = tms_in ? UPD_IR : PAU_IR;
         PAU_IR: tap_next = tms_in ? EX2_IR : PAU_IR;
         EX2_IR: tap_next = tms_in ? UPD_IR : SHF_IR;
         UPD_IR: tap_next = tms_in ? SEL_DR : RTI;
      endcase
   end

   // State register; five high mode-select edges always reach reset.
   always_ff @(posedge tck_in) begin
      if (!tck_rst_b) begin
         tap_reg <= TLR;
      end else begin
         tap_reg <= tap_next;
      end
   end

   // Instruction register: ten-bit capture, shift and update.
   always_ff @(posedge tck_in) begin
      if (!tck_rst_b || tap_reg == TLR) begin
         ir_shift_reg <= IR_CAPTURE;
         ir_reg       <= INS_ID_READ;
      end else if (tap_reg == CAP_IR) begin
         ir_shift_reg <= IR_CAPTURE;
      end else if (tap_reg == SHF_IR) begin
         ir_shift_reg <= {tdi_in, ir_shift_reg[IR_LEN-1:1]};
      end else if (tap_reg == UPD_IR) begin
         ir_reg <= ir_shift_reg;
      end
   end

   assign path = path_of(ir_reg);

   // Instruction in force after this edge; pin levels follow it at once, because the
   // test clock may stop right after an instruction update.
   assign ir_next = (tap_reg == TLR) ? INS_ID_READ :
                    (tap_reg == UPD_IR) ? ir_shift_reg : ir_reg;

   // Data shift stages; only the selected path moves.
   always_ff @(posedge tck_in) begin
      if (tap_reg == CAP_DR) begin
         bypass_reg    <= 1'b0;
         id_shift_reg  <= ID_VALUE;
         bsr_shift_reg <= {core_oe_s, pin_in_s};
         std_shift_reg <= std_upd_reg;
      end else if (tap_reg == SHF_DR) begin
         unique case (path)
            PATH_BYPASS: bypass_reg    <= tdi_in;
            PATH_ID:     id_shift_reg  <= {tdi_in, id_shift_reg[ID_LEN-1:1]};
            PATH_BSR:    bsr_shift_reg <= {tdi_in, bsr_shift_reg[BSR_LEN-1:1]};
            PATH_STD:    std_shift_reg <= {tdi_in, std_shift_reg[STD_LEN-1:1]};
            PATH_CFG:    cfg_shift_reg <= {tdi_in, cfg_shift_reg[CFG_W-1:1]};
         endcase
      end
   end

   // Update stages; preload works under sample as well as extest.
   always_ff @(posedge tck_in) begin
      if (!tck_rst_b) begin
         bsr_upd_reg <= '0;
         std_upd_reg <= STD_RESET;
      end else begin
         bsr_upd_reg <= bsr_upd_next;
         std_upd_reg <= std_upd_next;
      end
   end

   // Values the update stages take at this edge; offering them at once means a frame
   // that stops the test clock right after Update-DR still reaches the pins.
   assign bsr_upd_next = (tap_reg == UPD_DR && path == PATH_BSR) ? bsr_shift_reg
                                                                 : bsr_upd_reg;
   assign std_upd_next = (tap_reg == UPD_DR && path == PATH_STD) ? std_shift_reg
                                                                 : std_upd_reg;

   // Configuration bits gather into bytes that go over a toggle handshake.
   always_ff @(posedge tck_in) begin
      if (!tck_rst_b || tap_reg == CAP_DR) begin
         cfg_cnt_reg <= '0;
         if (!tck_rst_b) begin
            cfg_req_reg  <= 1'b0;
            cfg_hold_reg <= '0;
         end
      end else if (tap_reg == SHF_DR && path == PATH_CFG) begin
         cfg_cnt_reg <= cfg_cnt_reg + 3'h1;
         if (cfg_cnt_reg == CNT_LAST && cfg_req_reg == cfg_ack_s) begin
            cfg_hold_reg <= {tdi_in, cfg_shift_reg[CFG_W-1:1]};
            cfg_req_reg  <= ~cfg_req_reg;
         end
      end
   end

   // Update stages are re-offered whenever the system side is idle and differs.
   always_ff @(posedge tck_in) begin
      if (!tck_rst_b) begin
         upd_req_reg  <= 1'b0;
         bsr_hold_reg <= '0;
         std_hold_reg <= STD_RESET;
         mode_reg     <= 3'h0;
      end else begin
         mode_reg <= {ir_next == INS_CONFIG_IO, ir_next == INS_HIGHZ, ir_next == INS_EXTEST};
         if (upd_req_reg == upd_ack_s &&
             (bsr_hold_reg != bsr_upd_next || std_hold_reg != std_upd_next)) begin
            bsr_hold_reg <= bsr_upd_next;
            std_hold_reg <= std_upd_next;
            upd_req_reg  <= ~upd_req_reg;
         end
      end
   end

   // Serial output picks the least significant bit of the selected stage.
   always_comb begin
      sel_out = bypass_reg;
      if (tap_reg == SHF_IR) begin
         sel_out = ir_shift_reg[0];
      end else begin
         unique case (path)
            PATH_BYPASS: sel_out = bypass_reg;
            PATH_ID:     sel_out = id_shift_reg[0];
            PATH_BSR:    sel_out = bsr_shift_reg[0];
            PATH_STD:    sel_out = std_shift_reg[0];
            PATH_CFG:    sel_out = cfg_shift_reg[0];
         endcase
      end
   end

   // Serial output changes on the falling test clock edge, driven only in shift states.
   always_ff @(negedge tck_in) begin
      if (!tck_rst_b) begin
         tdo_out    <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else begin
         tdo_out    <= sel_out;
         tdo_oe_out <= (tap_reg == SHF_DR) || (tap_reg == SHF_IR);
      end
   end

   // ---------------- System clock domain ----------------
   logic [2:0]         mode_s;          // Extest, high-z, config-I/O.
   logic               upd_req_s;       // Synchronised update toggle.
   logic               cfg_req_s;       // Synchronised byte toggle.
   logic [BSR_LEN-1:0] bsr_sys_reg;     // Boundary pattern in the system domain.
   logic               halt_reg;        // Configuration halted by config-I/O.

   level_sync #(.WIDTH(5)) u_sys_sync (
      .clk_in (clk_sys_in),
      .d_in   ({mode_reg, upd_req_reg, cfg_req_reg}),
      .q_out  ({mode_s, upd_req_s, cfg_req_s})
   );

   // Takes the held patterns and bytes once their request toggle arrives.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         upd_ack_reg   <= 1'b0;
         cfg_ack_reg   <= 1'b0;
         bsr_sys_reg   <= '0;
         io_std_out    <= STD_RESET;
         cfg_byte_out  <= '0;
         cfg_valid_out <= 1'b0;
      end else begin
         cfg_valid_out <= 1'b0;
         if (upd_req_s != upd_ack_reg) begin
            bsr_sys_reg <= bsr_hold_reg;
            io_std_out  <= std_hold_reg;
            upd_ack_reg <= upd_req_s;
         end
         if (cfg_req_s != cfg_ack_reg) begin
            cfg_byte_out  <= cfg_hold_reg;
            cfg_valid_out <= 1'b1;
            cfg_ack_reg   <= cfg_req_s;
         end
      end
   end

   // Pin drive: extest pattern, high-z release, or core once configured.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         pin_out_out <= '0;
         pin_oe_out  <= '0;
      end else if (mode_s[0]) begin
         pin_out_out <= bsr_sys_reg[PIN_NUM-1:0];
         pin_oe_out  <= bsr_sys_reg[BSR_LEN-1:PIN_NUM];
      end else begin
         pin_out_out <= core_out_in;
         pin_oe_out  <= (mode_s[1] || !config_done_in || halt_reg) ? '0 : core_oe_in;
      end
   end

   // Config-I/O holds the status low; a reconfiguration start releases it, set wins.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         halt_reg                     <= 1'b0;
         config_status_low_active_out <= 1'b1;
      end else begin
         halt_reg                     <= mode_s[2] || (halt_reg && !reconfig_start_in);
         config_status_low_active_out <= !(mode_s[2] || (halt_reg && !reconfig_start_in));
      end
   end

   // ---------------- Checks ----------------
   default clocking @(posedge tck_in); endclocking
   default disable iff (!tck_rst_b);

   a_tms_reset_walk: assert property (tms_in [*5] |=> tap_reg == TLR)
      else $error("five high mode-select edges did not reach reset");
   a_reset_default_ir: assert property (tap_reg == TLR |=> ir_reg == INS_ID_READ)
      else $error("reset did not select identification");
   a_ir_ten_bits: assert property (tap_reg == UPD_IR |=> ir_reg == $past(ir_shift_reg))
      else $error("instruction update lost bits");
   a_bypass_zero_cap: assert property (tap_reg == CAP_DR && path == PATH_BYPASS
                                       |=> bypass_reg == 1'b0)
      else $error("bypass did not capture zero");
   a_bypass_one_stage: assert property (tap_reg == SHF_DR && ir_reg == INS_BYPASS
                                        |=> bypass_reg == $past(tdi_in))
      else $error("bypass is not a single stage");
   a_unknown_bypass: assert property (ir_reg == 10'h155 |-> path == PATH_BYPASS)
      else $error("unknown instruction not on bypass");
   a_id_lsb_one: assert property (tap_reg == CAP_DR && path == PATH_ID
                                  |=> id_shift_reg == ID_VALUE && id_shift_reg[0])
      else $error("identification capture wrong");
   a_sample_snapshot: assert property (tap_reg == CAP_DR && path == PATH_BSR
                       |=> bsr_shift_reg == $past({core_oe_s, pin_in_s}))
      else $error("boundary capture wrong");
   a_highz_path: assert property (ir_reg == INS_HIGHZ |-> path == PATH_BYPASS)
      else $error("high-z not on bypass");
   a_extest_drive: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
                   mode_s[0] |=> pin_oe_out == $past(bsr_sys_reg[BSR_LEN-1:PIN_NUM]))
      else $error("extest pattern not driven");
   a_powerup_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
                    !config_done_in && !mode_s[0] |=> pin_oe_out == '0)
      else $error("pins driven before configuration");
   a_cfgio_status: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
                   mode_s[2] |=> !config_status_low_active_out && halt_reg)
      else $error("config-I/O did not hold status low");
endmodule // boundary_scan_test_port

// *** bench/scan_controller_model.sv ***
// Model of the external scan controller on the test port's far side.
`timescale 1ns/10ps
module scan_controller_model
   import scan_port_pkg::*;
(
   // Lines toward the device.
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out,
   // Serial answer from the device.
   input  wire logic tdo_in
);
   // The clock stands still between frames; data idles high as with pull-ups, and so does mode except after go_reset.
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
   end

   // One 6 ns clock cycle; the answer is taken just before the rising edge.
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_out = tms;
      tdi_out = tdi;
      #3;
      tdo = tdo_in;
      tck_out = 1'b1;
      #3;
      tck_out = 1'b0;
   endtask

   // Shifts n bits from the low end, passes Update and parks in Run-Test/Idle.
   task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
      logic b;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      tms_out = 1'b1;
      tdi_out = 1'b1;
   endtask

   // Five mode-high cycles reset the state machine, then it parks in Run-Test/Idle.
   task automatic go_reset();
      logic b;
      repeat (5) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask

   // Loads a full ten-bit instruction and returns the captured bits.
   task automatic scan_ir(input logic [IR_LEN-1:0] code, output logic [IR_LEN-1:0] cap);
      logic        b;
      logic [31:0] d;
      step(1'b1, 1'b1, b);
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      step(1'b0, 1'b1, b);
      shift(IR_LEN, {22'h0, code}, d);
      cap = d[IR_LEN-1:0];
   endtask

   // Captures and shifts n data bits through the selected data register.
   task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
      logic b;
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      step(1'b0, 1'b1, b);
      shift(n, din, dout);
   endtask
endmodule // scan_controller_model

// *** bench/test_boundary_scan_test_port.sv ***
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/10ps
module test_boundary_scan_test_port
   import scan_port_pkg::*;
;
   // One table row: instruction, pin stimulus, shifted data and expected results.
   typedef struct packed {
      logic [IR_LEN-1:0]  code;
      logic [PIN_NUM-1:0] pin;
      logic [PIN_NUM-1:0] oe;
      logic [31:0]        din;
      logic [31:0]        dout;
      logic [PIN_NUM-1:0] exp_oe;
      logic [PIN_NUM-1:0] exp_out;
   } row_t;
   // Design inputs, all with a value at time zero.
   logic               clk_sys_in        = 1'b0;
   logic               rst_b_in          = 1'b0;
   logic [PIN_NUM-1:0] core_out_in       = 8'h3c;
   logic [PIN_NUM-1:0] core_oe_in        = 8'hff;
   logic [PIN_NUM-1:0] pin_in_in         = 8'h00;
   logic               config_done_in    = 1'b0;
   logic               reconfig_start_in = 1'b0;
   // Test port lines and design outputs.
   logic               tck, tms, tdi, tdo, tdo_oe;
   logic [PIN_NUM-1:0] pin_out, pin_oe;
   logic [STD_LEN-1:0] io_std;
   logic               status_b, cfg_valid;
   logic [CFG_W-1:0]   cfg_byte;
   // Scratch values and counters.
   logic [IR_LEN-1:0]  cap;
   logic [31:0]        dout;
   int                 miscompares = 0;
   int                 compares    = 0;
   // Ordinary cases; bypass-like codes return the input delayed by one zero stage.
   row_t rows [6] = '{
      '{INS_BYPASS,  8'h5a, 8'hc3, 32'hdead_beef, 32'hbd5b_7dde, 8'hc3, 8'h3c},
      '{INS_HIGHZ,   8'h5a, 8'hc3, 32'h1234_5679, 32'h2468_acf2, 8'h00, 8'h3c},
      '{10'h155,     8'h5a, 8'h0f, 32'h8000_0001, 32'h0000_0002, 8'h0f, 8'h3c},
      '{INS_ID_READ, 8'h5a, 8'h0f, 32'h0000_0000, ID_VALUE,      8'h0f, 8'h3c},
      '{INS_SAMPLE,  8'ha5, 8'h3c, 32'h9876_0000, 32'h0000_3ca5, 8'h3c, 8'h3c},
      '{INS_EXTEST,  8'h69, 8'h96, 32'h5ac3_ffff, 32'hffff_9669, 8'h5a, 8'hc3}};

   // System clock of 25 MHz.
   always #20 clk_sys_in = ~clk_sys_in;

   // Device under test.
   boundary_scan_test_port boundary_scan_test_port_i (
      .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tck_in(tck), .tms_in(tms),
      .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .core_out_in(core_out_in),
      .core_oe_in(core_oe_in), .pin_in_in(pin_in_in), .config_done_in(config_done_in),
      .reconfig_start_in(reconfig_start_in), .pin_out_out(pin_out), .pin_oe_out(pin_oe),
      .io_std_out(io_std), .config_status_low_active_out(status_b),
      .cfg_byte_out(cfg_byte), .cfg_valid_out(cfg_valid));

   // Controller on the far side of the test port.
   scan_controller_model scan_controller_model_i (
      .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));

   // Compares a seen value with the expected one and counts the result.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Lets the pin and status logic settle, sampling away from the rising edge.
   task automatic settle();
      repeat (12) @(negedge clk_sys_in);
   endtask

   // Holds reset six cycles while the test clock also runs, checking the quiet outputs.
   task automatic do_reset();
      @(posedge clk_sys_in);
      rst_b_in <= 1'b0;
      scan_controller_model_i.go_reset();
      repeat (5) @(negedge clk_sys_in);
      check("reset pin_oe", {24'h0, pin_oe}, 32'h0);
      check("reset status", {31'h0, status_b}, 32'h1);
      check("reset io_std", {16'h0, io_std}, {16'h0, STD_RESET});
      check("reset valid", {30'h0, cfg_valid, tdo_oe}, 32'h0);
      @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      // The release needs test clock edges to cross; park in Run-Test/Idle after it.
      scan_controller_model_i.go_reset();
      repeat (2) @(posedge clk_sys_in);
      $display("reset test done");
   endtask

   // Waits a bounded time for one configuration byte and checks it.
   task automatic wait_byte(input logic [7:0] exp);
      int i;
      for (i = 0; i < 50 && cfg_valid !== 1'b1; i++) @(negedge clk_sys_in);
      if (i == 50) begin
         miscompares++;
         test_done();
      end else begin
         check("cfg byte", {24'h0, cfg_byte}, {24'h0, exp});
         @(negedge clk_sys_in);
      end
   endtask

   // Main sequence.
   initial begin
      do_reset();
      // Default instruction reads the identification value, lowest bit one.
      scan_controller_model_i.scan_dr(32, 32'h0, dout);
      check("id after reset", dout, ID_VALUE);
      settle();
      check("pins before config", {24'h0, pin_oe}, 32'h0);
      // The table rows are scanned only once configuration has completed.
      @(posedge clk_sys_in);
      config_done_in <= 1'b1;
      foreach (rows[k]) begin
         @(posedge clk_sys_in);
         pin_in_in  <= rows[k].pin;
         core_oe_in <= rows[k].oe;
         scan_controller_model_i.scan_ir(rows[k].code, cap);
         check("ir capture", {22'h0, cap}, {22'h0, IR_CAPTURE});
         scan_controller_model_i.scan_dr(32, rows[k].din, dout);
         check("dr out", dout, rows[k].dout);
         settle();
         check("pin_oe", {24'h0, pin_oe}, {24'h0, rows[k].exp_oe});
         if (rows[k].code != INS_HIGHZ) check("pin_out", {24'h0, pin_out}, {24'h0, rows[k].exp_out});
         $display("row %0d test done", k);
      end
      // Two configuration bytes, each captured afresh, with a pause between them.
      scan_controller_model_i.scan_ir(INS_CFG_LOAD, cap);
      foreach (rows[k]) if (k < 2) begin
         fork
            scan_controller_model_i.scan_dr(8, {24'h0, rows[k].pin ^ 8'h81}, dout);
            wait_byte(rows[k].pin ^ 8'h81);
         join
         repeat (8) @(posedge clk_sys_in);
      end
      $display("config load test done");
      // Standards chain rewrites every pin while configuration is halted.
      scan_controller_model_i.scan_ir(INS_CONFIG_IO, cap);
      settle();
      check("halt status", {31'h0, status_b}, 32'h0);
      scan_controller_model_i.scan_dr(STD_LEN, 32'h0000_b4e1, dout);
      check("std capture", dout, {16'h0, STD_RESET});
      settle();
      check("io_std", {16'h0, io_std}, 32'h0000_b4e1);
      check("halt pins", {24'h0, pin_oe}, 32'h0);
      scan_controller_model_i.scan_ir(INS_BYPASS, cap);
      settle();
      check("still halted", {31'h0, status_b}, 32'h0);
      @(posedge clk_sys_in);
      reconfig_start_in <= 1'b1;
      @(posedge clk_sys_in);
      reconfig_start_in <= 1'b0;
      settle();
      check("released", {31'h0, status_b}, 32'h1);
      $display("config io test done");
      // Five mode-high cycles bring back the identification instruction.
      scan_controller_model_i.go_reset();
      scan_controller_model_i.scan_dr(32, 32'h0, dout);
      check("id after tap reset", dout, ID_VALUE);
      $display("tap reset test done");
      // A second reset in mid-run, while configuration is halted.
      scan_controller_model_i.scan_ir(INS_CONFIG_IO, cap);
      settle();
      do_reset();
      test_done();
   end
endmodule // test_boundary_scan_test_port
